// *** rtl/blcu_pkg.sv ***
// blcu_pkg.sv: constants and types of the bit logic contact unit
package blcu_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int STACK_DEPTH = 32'h9;    // logic stack levels, top is bit 0
    localparam int EDGE_SLOTS = 32'h100;   // transition instances
    localparam int IMAGE_BITS = 32'h80;    // 16 bytes of image or pins
    localparam int BOX_INPUTS = 32'h20;    // widest box
    localparam logic [5:0] BOX_MAX = 6'h20;

    // ****************************************
    // operand areas and their last byte
    // ****************************************
    typedef enum logic [3:0] {
        AREA_IN = 4'h0, AREA_OUT = 4'h1, AREA_VAR = 4'h2, AREA_BITMEM = 4'h3,
        AREA_SPECIAL = 4'h4, AREA_SEQ = 4'h5, AREA_TIMER = 4'h6,
        AREA_COUNTER = 4'h7, AREA_LOCAL = 4'h8, AREA_POWER = 4'h9,
        AREA_FAST_COUNTER_VALUE = 4'ha, AREA_WORK_REGISTER = 4'hb
    } blcu_area_t;
    localparam logic [13:0] LAST_IMAGE = 14'h00f;
    localparam logic [13:0] LAST_VAR = 14'h07ff;
    localparam logic [13:0] LAST_BITMEM = 14'h001f;
    localparam logic [13:0] LAST_SPECIAL = 14'h00a5;
    localparam logic [13:0] LAST_SEQ = 14'h001f;
    localparam logic [13:0] LAST_TC = 14'h00ff;
    localparam logic [13:0] LAST_LOCAL = 14'h003f;
    localparam logic [13:0] LAST_FAST = 14'h0005;
    localparam logic [13:0] LAST_WORK = 14'h0003;
    localparam logic [13:0] DWORD_SPAN = 14'h0003;

    typedef enum logic [1:0] {W_BIT = 2'h0, W_BYTE = 2'h1, W_DWORD = 2'h2} blcu_width_t;

    // ****************************************
    // instructions
    // ****************************************
    typedef enum logic [4:0] {
        OP_OPEN_CONTACT_PUSH = 5'h00, OP_OPEN_CONTACT_AND = 5'h01,
        OP_OPEN_CONTACT_OR = 5'h02, OP_CLOSED_CONTACT_PUSH = 5'h03,
        OP_CLOSED_CONTACT_AND = 5'h04, OP_CLOSED_CONTACT_OR = 5'h05,
        OP_OPEN_DIRECT_PUSH = 5'h06, OP_OPEN_DIRECT_AND = 5'h07,
        OP_OPEN_DIRECT_OR = 5'h08, OP_CLOSED_DIRECT_PUSH = 5'h09,
        OP_CLOSED_DIRECT_AND = 5'h0a, OP_CLOSED_DIRECT_OR = 5'h0b,
        OP_INVERT = 5'h0c, OP_RISING_PULSE = 5'h0d, OP_FALLING_PULSE = 5'h0e,
        OP_BOX_AND = 5'h0f, OP_BOX_OR = 5'h10, OP_RANGE_CHECK = 5'h11
    } blcu_op_t;

    // how a value meets the top of stack
    localparam logic [1:0] COMB_PUSH = 2'h0;
    localparam logic [1:0] COMB_AND = 2'h1;
    localparam logic [1:0] COMB_OR = 2'h2;

    // one-hot sequencer states
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_FETCH = 2'b10} blcu_fsm_t;

endpackage

// *** rtl/blcu_oper_if.sv ***
// blcu_oper_if.sv: operand request and decode answer between unit and decoder
`timescale 1ns/10ps
`default_nettype none
interface blcu_oper_if;
    import blcu_pkg::*;
    blcu_area_t area;       // operand area
    logic [13:0] byte_addr; // byte, or timer/counter number
    logic [2:0] bit_sel;    // bit in byte
    blcu_width_t width;     // access width for range checks
    logic direct;           // direct form, reads pins
    logic ok;               // address legal for area and form
    logic from_image;       // answered without data memory
    logic image_bit;        // value from image or pins

    modport unit (output area, output byte_addr, output bit_sel, output width,
                  output direct, input ok, input from_image, input image_bit);
    modport dec (input area, input byte_addr, input bit_sel, input width,
                 input direct, output ok, output from_image, output image_bit);
endinterface
`default_nettype wire

// *** rtl/blcu_operand_decode.sv ***
// blcu_operand_decode.sv: operand range check and image/pin bit selection
`timescale 1ns/10ps
`default_nettype none
module blcu_operand_decode
(
    // operand request from the unit
    blcu_oper_if.dec oper,
    // image registers and physical pins
    input wire logic [blcu_pkg::IMAGE_BITS-1:0] i_image_in,
    input wire logic [blcu_pkg::IMAGE_BITS-1:0] i_image_out,
    input wire logic [blcu_pkg::IMAGE_BITS-1:0] i_phys_in
);
    import blcu_pkg::*;

    // ****************************************
    // last legal start byte for an area and width
    // ****************************************
    function automatic logic range_ok(blcu_area_t a, blcu_width_t w, logic [13:0] b);
        logic [13:0] last;
        logic is_dw;
        last = 14'h0000;
        is_dw = (w == W_DWORD);
        case (a)
            AREA_IN, AREA_OUT: last = LAST_IMAGE;
            AREA_VAR: last = LAST_VAR;
            AREA_BITMEM: last = LAST_BITMEM;
            AREA_SPECIAL: last = LAST_SPECIAL;
            AREA_SEQ: last = LAST_SEQ;
            AREA_TIMER, AREA_COUNTER: last = LAST_TC;
            AREA_LOCAL: last = LAST_LOCAL;
            AREA_FAST_COUNTER_VALUE: last = LAST_FAST;
            AREA_WORK_REGISTER: last = LAST_WORK;
            default: last = 14'h0000;
        endcase
        // counter values exist only as doublewords, work regs never as bits
        if (a == AREA_FAST_COUNTER_VALUE)
            return is_dw && (b <= last);
        if (a == AREA_WORK_REGISTER)
            return (w != W_BIT) && (b <= last);
        if (a == AREA_POWER)
            return (w == W_BIT);
        if (is_dw && (a == AREA_TIMER || a == AREA_COUNTER))
            return 1'b0;
        // a doubleword must end inside the area: input 0 to 12
        if (is_dw)
            return ({1'b0, b} + {1'b0, DWORD_SPAN}) <= {1'b0, last};
        return b <= last;
    endfunction

    logic [6:0] bit_index; // flat bit number inside 16 bytes
    assign bit_index = {oper.byte_addr[3:0], oper.bit_sel};

    // direct forms accept only the input area
    assign oper.ok = oper.direct ? (oper.area == AREA_IN && oper.width == W_BIT
                                    && oper.byte_addr <= LAST_IMAGE)
                                 : range_ok(oper.area, oper.width, oper.byte_addr);
    // pins for direct forms, image for input/output areas
    assign oper.from_image = oper.direct || oper.area == AREA_IN
                             || oper.area == AREA_OUT;
    assign oper.image_bit = oper.direct ? i_phys_in[bit_index]
                          : (oper.area == AREA_OUT) ? i_image_out[bit_index]
                          : i_image_in[bit_index];

endmodule
`default_nettype wire

// *** rtl/blcu_contact_unit.sv ***
// blcu_contact_unit.sv: logic stack evaluation of contact, inversion and pulse instructions
`timescale 1ns/10ps
`default_nettype none
module blcu_contact_unit
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // instruction from the sequencer
    input wire logic i_instr_valid,
    input wire blcu_pkg::blcu_op_t i_op,
    input wire blcu_pkg::blcu_area_t i_area,
    input wire logic [13:0] i_byte_addr,
    input wire logic [2:0] i_bit_sel,
    input wire blcu_pkg::blcu_width_t i_width,
    input wire logic [7:0] i_edge_slot,
    input wire logic [blcu_pkg::BOX_INPUTS-1:0] i_box_in,
    input wire logic [5:0] i_box_count,
    input wire logic i_power_flow,
    output logic o_instr_ready,
    output logic o_done,
    output logic o_fault,
    output logic o_range_ok,
    // image registers and physical pins
    input wire logic [blcu_pkg::IMAGE_BITS-1:0] i_image_in,
    input wire logic [blcu_pkg::IMAGE_BITS-1:0] i_image_out,
    input wire logic [blcu_pkg::IMAGE_BITS-1:0] i_phys_in,
    // data memory read
    output logic o_mem_req,
    output blcu_pkg::blcu_area_t o_mem_area,
    output logic [13:0] o_mem_byte,
    output logic [2:0] o_mem_bit,
    input wire logic i_mem_ack,
    input wire logic i_mem_bit,
    // logic stack
    output logic o_tos,
    output logic [blcu_pkg::STACK_DEPTH-1:0] o_stack
);
    import blcu_pkg::*;

    // ****************************************
    // state and decode
    // ****************************************
    typedef struct packed {
        blcu_fsm_t fsm;                 // sequencer state
        logic [STACK_DEPTH-1:0] stack;  // bit 0 is top
        logic [EDGE_SLOTS-1:0] prev;    // last top seen per pulse slot
        logic [EDGE_SLOTS-1:0] seen;    // slot has run at least once
        logic negate;                   // pending fetch is a closed contact
        logic [1:0] comb;               // pending fetch combine mode
        logic mem_req;                  // memory read outstanding
        blcu_area_t mem_area;           // read area
        logic [13:0] mem_byte;          // read byte
        logic [2:0] mem_bit;            // read bit
        logic done;                     // completion pulse
        logic fault;                    // bad operand pulse
        logic range_ok;                 // last range check answer
    } blcu_state_t;

    typedef struct packed {
        logic contact;  // any contact form
        logic negate;   // closed contact
        logic direct;   // reads pins
        logic [1:0] comb;
    } blcu_dec_t;

    blcu_state_t cur;       // registered state
    blcu_state_t next_cur;  // next state
    blcu_dec_t dec;         // decode of i_op
    blcu_oper_if oper ();   // to the operand decoder
    logic take;             // instruction accepted this cycle
    logic [BOX_INPUTS-1:0] box_mask; // live box inputs
    logic [32:0] box_ones;  // wide helper for the mask

    // instruction fields into combine mode, polarity and source
    function automatic blcu_dec_t decode(blcu_op_t op);
        blcu_dec_t d;
        d = '0;
        case (op)
            OP_OPEN_CONTACT_PUSH: d = '{1'b1, 1'b0, 1'b0, COMB_PUSH};
            OP_OPEN_CONTACT_AND: d = '{1'b1, 1'b0, 1'b0, COMB_AND};
            OP_OPEN_CONTACT_OR: d = '{1'b1, 1'b0, 1'b0, COMB_OR};
            OP_CLOSED_CONTACT_PUSH: d = '{1'b1, 1'b1, 1'b0, COMB_PUSH};
            OP_CLOSED_CONTACT_AND: d = '{1'b1, 1'b1, 1'b0, COMB_AND};
            OP_CLOSED_CONTACT_OR: d = '{1'b1, 1'b1, 1'b0, COMB_OR};
            OP_OPEN_DIRECT_PUSH: d = '{1'b1, 1'b0, 1'b1, COMB_PUSH};
            OP_OPEN_DIRECT_AND: d = '{1'b1, 1'b0, 1'b1, COMB_AND};
            OP_OPEN_DIRECT_OR: d = '{1'b1, 1'b0, 1'b1, COMB_OR};
            OP_CLOSED_DIRECT_PUSH: d = '{1'b1, 1'b1, 1'b1, COMB_PUSH};
            OP_CLOSED_DIRECT_AND: d = '{1'b1, 1'b1, 1'b1, COMB_AND};
            OP_CLOSED_DIRECT_OR: d = '{1'b1, 1'b1, 1'b1, COMB_OR};
            default: d = '0;
        endcase
        return d;
    endfunction

    // contact value into the stack; used for image and memory operands
    function automatic logic [STACK_DEPTH-1:0] apply(logic [STACK_DEPTH-1:0] s,
                                                      logic v, logic neg, logic [1:0] c);
        logic x;
        x = v ^ neg;
        case (c)
            COMB_AND: return {s[STACK_DEPTH-1:1], s[0] & x};
            COMB_OR: return {s[STACK_DEPTH-1:1], s[0] | x};
            default: return {s[STACK_DEPTH-2:0], x};
        endcase
    endfunction

    assign dec = decode(i_op);
    assign o_instr_ready = (cur.fsm == ST_IDLE);
    assign take = i_instr_valid && o_instr_ready;

    // ****************************************
    // operand decoder
    // ****************************************
    assign oper.area = i_area;
    assign oper.byte_addr = i_byte_addr;
    assign oper.bit_sel = i_bit_sel;
    assign oper.width = (dec.contact) ? W_BIT : i_width;
    assign oper.direct = dec.direct;

    blcu_operand_decode u_decode
    (
        .oper(oper.dec),
        .i_image_in(i_image_in),
        .i_image_out(i_image_out),
        .i_phys_in(i_phys_in)
    );

    // box inputs 0..count-1 are live; count 1 to 32
    assign box_ones = (33'h000000001 << i_box_count) - 33'h000000001;
    assign box_mask = box_ones[BOX_INPUTS-1:0];

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.fault = 1'b0;
        case (cur.fsm)
            ST_IDLE:
            begin
                if (take)
                begin
                    next_cur.done = 1'b1;
                    if (dec.contact)
                    begin
                        if (!oper.ok)
                            // illegal address leaves the stack alone
                            next_cur.fault = 1'b1;
                        else if (oper.from_image)
                            // image or pin bit, no memory trip
                            next_cur.stack = apply(cur.stack, oper.image_bit, dec.negate,
                                                   dec.comb);
                        else if (i_area == AREA_POWER)
                            next_cur.stack = apply(cur.stack, i_power_flow, dec.negate,
                                                   dec.comb);
                        else
                        begin
                            // every other area waits for data memory
                            next_cur.done = 1'b0;
                            next_cur.fsm = ST_FETCH;
                            next_cur.mem_req = 1'b1;
                            next_cur.mem_area = i_area;
                            next_cur.mem_byte = i_byte_addr;
                            next_cur.mem_bit = i_bit_sel;
                            next_cur.negate = dec.negate;
                            next_cur.comb = dec.comb;
                        end
                    end
                    else
                    begin
                        case (i_op)
                            OP_INVERT:
                                next_cur.stack[0] = ~cur.stack[0];
                            OP_RISING_PULSE, OP_FALLING_PULSE:
                            begin
                                // no edge until the slot holds a real previous value
                                if (!cur.seen[i_edge_slot])
                                    next_cur.stack[0] = 1'b0;
                                else if (i_op == OP_RISING_PULSE)
                                    next_cur.stack[0] = cur.stack[0]
                                                        & ~cur.prev[i_edge_slot];
                                else
                                    next_cur.stack[0] = ~cur.stack[0]
                                                        & cur.prev[i_edge_slot];
                                next_cur.prev[i_edge_slot] = cur.stack[0];
                                next_cur.seen[i_edge_slot] = 1'b1;
                            end
                            OP_BOX_AND, OP_BOX_OR:
                            begin
                                if (i_box_count == 6'h00 || i_box_count > BOX_MAX)
                                    next_cur.fault = 1'b1;
                                else if (i_op == OP_BOX_AND)
                                    next_cur.stack = {cur.stack[STACK_DEPTH-2:0],
                                                      &(i_box_in | ~box_mask)};
                                else
                                    next_cur.stack = {cur.stack[STACK_DEPTH-2:0],
                                                      |(i_box_in & box_mask)};
                            end
                            OP_RANGE_CHECK:
                                next_cur.range_ok = oper.ok;
                            default:
                                next_cur.fault = 1'b1; // unknown code
                        endcase
                    end
                end
            end
            ST_FETCH:
            begin
                // request stands until the memory answers
                if (i_mem_ack)
                begin
                    next_cur.stack = apply(cur.stack, i_mem_bit, cur.negate, cur.comb);
                    next_cur.mem_req = 1'b0;
                    next_cur.done = 1'b1;
                    next_cur.fsm = ST_IDLE;
                end
            end
            default:
                next_cur.fsm = ST_IDLE; // recover from a broken code
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cur <= '0;
            cur.fsm <= ST_IDLE;
            cur.mem_area <= AREA_IN;
        end
        else
            cur <= next_cur;
    end

    assign o_done = cur.done;
    assign o_fault = cur.fault;
    assign o_range_ok = cur.range_ok;
    assign o_mem_req = cur.mem_req;
    assign o_mem_area = cur.mem_area;
    assign o_mem_byte = cur.mem_byte;
    assign o_mem_bit = cur.mem_bit;
    assign o_stack = cur.stack;
    assign o_tos = cur.stack[0];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    logic good_direct;   // accepted legal direct contact
    logic mem_contact;   // accepted contact that needs memory
    assign good_direct = take && dec.contact && dec.direct && oper.ok;
    assign mem_contact = take && dec.contact && oper.ok && !oper.from_image
                         && i_area != AREA_POWER;

    sequence fetch_start;
        mem_contact ##1 (o_mem_req && !o_instr_ready);
    endsequence
    sequence fetch_end;
        i_mem_ack ##1 (o_done && !o_mem_req && o_instr_ready);
    endsequence

    chk_invert_top: assert property (take && i_op == OP_INVERT |=>
        o_tos == !$past(o_tos) && o_stack[8:1] == $past(o_stack[8:1]))
        else $error("inversion did not complement top");
    chk_push_shift: assert property (good_direct && dec.comb == COMB_PUSH |=>
        o_stack[8:1] == $past(o_stack[7:0]))
        else $error("push did not shift stack down");
    chk_direct_value: assert property (good_direct && dec.comb == COMB_PUSH |=>
        o_tos == ($past(oper.image_bit) ^ $past(dec.negate)))
        else $error("direct contact pushed wrong value");
    chk_first_pulse: assert property (take && (i_op == OP_RISING_PULSE || i_op == OP_FALLING_PULSE)
        && !cur.seen[i_edge_slot] |=> !o_tos && o_done)
        else $error("edge reported on first execution");
    chk_rise_edge: assert property (take && i_op == OP_RISING_PULSE
        && cur.seen[i_edge_slot] |=> o_tos == ($past(o_tos) && !$past(cur.prev[i_edge_slot])))
        else $error("rising pulse wrong");
    chk_fall_edge: assert property (take && i_op == OP_FALLING_PULSE
        && cur.seen[i_edge_slot] |=> o_tos == (!$past(o_tos) && $past(cur.prev[i_edge_slot])))
        else $error("falling pulse wrong");
    // the read address must be the operand that was taken
    chk_mem_fetch: assert property (fetch_start |-> o_mem_byte == $past(i_byte_addr)
        && o_mem_bit == $past(i_bit_sel) && o_mem_area == $past(i_area))
        else $error("memory fetch address wrong");
    // request and address stand until the memory answers
    chk_mem_answer: assert property (cur.fsm == ST_FETCH && !i_mem_ack |=>
        o_mem_req && !o_instr_ready && $stable(o_mem_byte) && $stable(o_mem_bit))
        else $error("memory request dropped before answer");
    chk_image_local: assert property (take && dec.contact && oper.ok && oper.from_image |=>
        o_done && !o_mem_req && o_instr_ready)
        else $error("image operand went to memory");
    chk_bad_operand: assert property (take && dec.contact && !oper.ok |=>
        o_fault && o_stack == $past(o_stack) && !o_mem_req)
        else $error("illegal operand not refused");
    chk_fetch_done: assert property (cur.fsm == ST_FETCH && i_mem_ack |-> fetch_end)
        else $error("fetch completion wrong");

endmodule
`default_nettype wire

// *** verif/blcu_mem_model.sv ***
// blcu_mem_model.sv: data memory model that answers bit reads, promptly and after a stall in turn
`timescale 1ns/10ps
`default_nettype none
module blcu_mem_model
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // read request and its answer
    input wire logic i_req,
    input wire blcu_pkg::blcu_area_t i_area,
    input wire logic [13:0] i_byte,
    input wire logic [2:0] i_bit,
    output logic o_ack,
    output logic o_bit
);
    import blcu_pkg::*;
    logic [2:0] wait_cnt; // cycles the current read has waited
    logic slow; // flips per read so both latencies are seen
    logic answer; // answer in this cycle
    assign answer = i_req && !o_ack && wait_cnt == {slow, 2'h0};
    // data line toggles outside an answer, so a stale bit never matches by luck
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_ack <= 1'h0;
            o_bit <= 1'h0;
            wait_cnt <= 3'h0;
            slow <= 1'h0;
        end
        else
        begin
            o_ack <= answer;
            o_bit <= answer ? i_byte[0] ^ i_bit[0] ^ i_area[0] : ~o_bit;
            wait_cnt <= (i_req && !o_ack) ? wait_cnt + 3'h1 : 3'h0;
            slow <= slow ^ o_ack;
        end
    end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// tb_top.sv: self-checking bench of the bit logic contact unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import blcu_pkg::*;
    logic i_clk = 1'h0, i_sys_rst = 1'h1, i_instr_valid = 1'h0, i_power_flow = 1'h0;
    logic i_mem_ack, i_mem_bit, o_instr_ready, o_done, o_fault, o_range_ok, o_mem_req, o_tos;
    blcu_op_t i_op = OP_INVERT;
    blcu_area_t i_area = AREA_IN, o_mem_area;
    blcu_width_t i_width = W_BIT;
    logic [13:0] i_byte_addr = 14'h0, o_mem_byte;
    logic [2:0] i_bit_sel = 3'h0, o_mem_bit;
    logic [7:0] i_edge_slot = 8'h0;
    logic [5:0] i_box_count = 6'h1;
    logic [31:0] i_box_in = 32'h0;
    logic [127:0] i_image_in = 128'h20, i_image_out = ~(128'h1 << 26), i_phys_in = 128'h1 << 23;
    logic [8:0] o_stack, exp_stack = 9'h0; // expected stack, bit 0 on top
    int errors = 0, comparisons = 0, cycles = 0;
    blcu_contact_unit u_blcu_contact_unit (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_instr_valid(i_instr_valid),
        .i_op(i_op), .i_area(i_area), .i_byte_addr(i_byte_addr), .i_bit_sel(i_bit_sel), .i_width(i_width),
        .i_edge_slot(i_edge_slot), .i_box_in(i_box_in), .i_box_count(i_box_count), .i_power_flow(i_power_flow),
        .o_instr_ready(o_instr_ready), .o_done(o_done), .o_fault(o_fault), .o_range_ok(o_range_ok),
        .i_image_in(i_image_in), .i_image_out(i_image_out), .i_phys_in(i_phys_in), .o_mem_req(o_mem_req),
        .o_mem_area(o_mem_area), .o_mem_byte(o_mem_byte), .o_mem_bit(o_mem_bit), .i_mem_ack(i_mem_ack),
        .i_mem_bit(i_mem_bit), .o_tos(o_tos), .o_stack(o_stack));
    blcu_mem_model u_blcu_mem_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(o_mem_req), .i_area(o_mem_area),
        .i_byte(o_mem_byte), .i_bit(o_mem_bit), .o_ack(i_mem_ack), .o_bit(i_mem_bit));
    initial forever #2.5 i_clk = ~i_clk;
    // a full run needs well under a thousand cycles
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            errors++;
            $display("ERROR t=%0t run hangs", $time);
            conclude();
        end
    end
    task automatic conclude();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic expect9(input logic [8:0] got, input logic [8:0] want);
        comparisons++;
        if (got !== want)
        begin
            errors++;
            $display("ERROR t=%0t got %h want %h", $time, got, want);
        end
    endtask
    // c: 0 push, 1 and, 2 or; a push drops the deepest level
    function automatic void put(input int c, input logic v);
        exp_stack = c == 0 ? {exp_stack[7:0], v} : {exp_stack[8:1], c == 1 ? exp_stack[0] & v : exp_stack[0] | v};
    endfunction
    // offer one instruction, wait for completion, judge fault and stack; f < 0 leaves fault unjudged
    task automatic run(input blcu_op_t op, input blcu_area_t a, input int b, input int s, input int f);
        int n;
        i_op = op;
        i_area = a;
        i_byte_addr = 14'(b);
        i_bit_sel = 3'(s);
        i_instr_valid = 1'h1;
        @(negedge i_clk);
        i_instr_valid = 1'h0;
        n = 0;
        while (o_done !== 1'h1 && n < 20)
        begin
            @(negedge i_clk);
            n++;
        end
        expect9({7'h0, o_done, o_fault | (f < 0)}, {7'h0, 1'h1, f != 0});
        expect9(o_stack, exp_stack);
        expect9(9'(o_tos), 9'(exp_stack[0]));
    endtask
    task automatic t_contacts();
        for (int k = 0; k < 12; k++)
        begin
            put((k % 6) % 3, (k < 6) ^ ((k % 6) >= 3));
            run(blcu_op_t'(k % 6), k < 6 ? AREA_IN : AREA_OUT, k < 6 ? 0 : 3, k < 6 ? 5 : 2, 0);
        end
    endtask
    // pin bit 23 is high while its image copy is low
    task automatic t_direct();
        for (int k = 6; k < 12; k++)
        begin
            put((k - 6) % 3, k < 9);
            run(blcu_op_t'(k), AREA_IN, 2, 7, 0);
        end
        run(OP_OPEN_DIRECT_PUSH, AREA_OUT, 2, 7, 1);
        run(OP_OPEN_CONTACT_PUSH, AREA_IN, 16, 0, 1);
        run(OP_CLOSED_CONTACT_AND, AREA_VAR, 2048, 0, 1);
    endtask
    task automatic t_pulse(input logic v, input blcu_op_t op, input int s, input logic e);
        i_power_flow = v;
        put(0, v);
        run(OP_OPEN_CONTACT_PUSH, AREA_POWER, 0, 0, 0);
        i_edge_slot = 8'(s);
        exp_stack[0] = e;
        run(op, AREA_IN, 0, 0, 0);
        exp_stack[0] = ~e;
        run(OP_INVERT, AREA_IN, 0, 0, 0);
    endtask
    task automatic t_mem(input blcu_op_t op, input blcu_area_t a, input int b, input int s, input int c, input logic inv);
        put(c, b[0] ^ s[0] ^ a[0] ^ inv);
        run(op, a, b, s, 0);
    endtask
    task automatic t_range(input blcu_area_t a, input int b, input blcu_width_t w, input logic ok);
        i_width = w;
        run(OP_RANGE_CHECK, a, b, 0, -1);
        expect9(9'(o_range_ok), 9'(ok));
    endtask
    task automatic t_box(input blcu_op_t op, input logic [31:0] in, input int n, input logic e, input int f);
        i_box_in = in;
        i_box_count = 6'(n);
        if (f == 0)
            put(0, e);
        run(op, AREA_IN, 0, 0, f);
    endtask
    initial
    begin
        repeat (4) @(negedge i_clk);
        i_sys_rst = 1'h0;
        t_contacts();
        t_direct();
        t_pulse(1'h0, OP_RISING_PULSE, 3, 1'h0);
        t_pulse(1'h1, OP_RISING_PULSE, 3, 1'h1);
        t_pulse(1'h1, OP_RISING_PULSE, 3, 1'h0);
        t_pulse(1'h1, OP_FALLING_PULSE, 4, 1'h0);
        t_pulse(1'h0, OP_FALLING_PULSE, 4, 1'h1);
        t_pulse(1'h1, OP_RISING_PULSE, 5, 1'h0);
        t_mem(OP_OPEN_CONTACT_PUSH, AREA_VAR, 2047, 7, 0, 1'h0);
        t_mem(OP_CLOSED_CONTACT_OR, AREA_BITMEM, 31, 0, 2, 1'h1);
        t_mem(OP_OPEN_CONTACT_AND, AREA_TIMER, 255, 0, 1, 1'h0);
        t_mem(OP_CLOSED_CONTACT_PUSH, AREA_LOCAL, 63, 6, 0, 1'h1);
        t_range(AREA_IN, 12, W_DWORD, 1'h1);
        t_range(AREA_IN, 13, W_DWORD, 1'h0);
        t_range(AREA_FAST_COUNTER_VALUE, 5, W_DWORD, 1'h1);
        t_range(AREA_FAST_COUNTER_VALUE, 6, W_DWORD, 1'h0);
        t_range(AREA_WORK_REGISTER, 4, W_DWORD, 1'h0);
        t_range(AREA_OUT, 15, W_BYTE, 1'h1);
        t_range(AREA_OUT, 16, W_BYTE, 1'h0);
        t_box(OP_BOX_AND, 32'h7fff_ffff, 31, 1'h1, 0);
        t_box(OP_BOX_AND, 32'h7fff_ffff, 32, 1'h0, 0);
        t_box(OP_BOX_OR, 32'h8000_0000, 31, 1'h0, 0);
        t_box(OP_BOX_OR, 32'h8000_0000, 32, 1'h1, 0);
        t_box(OP_BOX_OR, 32'hffff_ffff, 33, 1'h0, 1);
        t_box(OP_BOX_AND, 32'h0, 0, 1'h0, 1);
        run(blcu_op_t'(5'h1f), AREA_IN, 0, 0, 1);
        conclude();
    end
endmodule
`default_nettype wire
